/* shared/lord_consts.svh */
// constants for the line option register decode block
`ifndef LORD_CONSTS_SVH
`define LORD_CONSTS_SVH
`define LORD_RESET_VALUE 8'h1D
`define LORD_USED_MASK 8'h3F
`define LORD_LB_BIT 0
`define LORD_RATE_LSB 1
`define LORD_RATE_MSB 3
`define LORD_PAR_LSB 4
`define LORD_PAR_MSB 5
`define LORD_AUX_RATE_LOCK_BIT 3
`define LORD_DEC_RADIX 8'h0A
`define LORD_DEC_DIGITS 3
`endif

/* shared/lord_pkg.sv */
// types for the line option register decode block
package lord_pkg;
  typedef enum logic [2:0] {
    LORD_RATE_300,
    LORD_RATE_57600,
    LORD_RATE_1200,
    LORD_RATE_2400,
    LORD_RATE_4800,
    LORD_RATE_9600,
    LORD_RATE_19200,
    LORD_RATE_38400
  } lord_rate_t;
  typedef enum logic [1:0] {
    LORD_PAR_CODE0,
    LORD_PAR_SPACE,
    LORD_PAR_CODE2,
    LORD_PAR_CODE3
  } lord_parity_t;
  typedef logic [7:0] lord_byte_t;
endpackage

/* shared/lord_dec_if.sv */
// carrier between the register core and the decimal reply formatter
`timescale 1ns/1ps
interface lord_dec_if;
  import lord_pkg::*;
  lord_byte_t value;
  logic [3:0] hundreds;
  logic [3:0] tens;
  logic [3:0] ones;
  modport core (output value, input hundreds, input tens, input ones);
  modport conv (input value, output hundreds, output tens, output ones);
endinterface

/* verilog/lord_bin2dec.sv */
// binary byte to three decimal digits for option query replies
`timescale 1ns/1ps
`include "lord_consts.svh"
module lord_bin2dec (
  lord_dec_if.conv dec
);
  import lord_pkg::*;
  logic [7:0] rem_hund;
  always_comb begin
    rem_hund = dec.value % `LORD_DEC_RADIX;
    dec.ones = rem_hund[3:0];
    dec.tens = 4'((dec.value / `LORD_DEC_RADIX) % `LORD_DEC_RADIX);
    dec.hundreds = 4'(dec.value / (`LORD_DEC_RADIX * `LORD_DEC_RADIX));
  end
endmodule

/* verilog/lord_top.sv */
// line option register: storage, field decode and decimal readback
`timescale 1ns/1ps
`include "lord_consts.svh"
// Function
// - bit 0 set accepts remote loopback requests, clear denies them.
// - rate code applies only while auxiliary option bit 3 is clear.
// - reset value is decimal 29: loopback on, 19200 bps, space parity.
// - host writes the value as a binary byte and reads it as decimal; only bits 5..0 are kept, bits 7..6 read as 0.
module lord_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wr,
  input wire lord_pkg::lord_byte_t i_wr_value,
  input wire logic i_query,
  input wire logic i_loopback_accept_cmd,
  input wire logic i_loopback_deny_cmd,
  input wire lord_pkg::lord_byte_t i_aux_option_register,
  input wire logic i_remote_loopback_request,
  output lord_pkg::lord_byte_t o_value,
  output logic o_reply_valid,
  output logic [3:0] o_reply_hundreds,
  output logic [3:0] o_reply_tens,
  output logic [3:0] o_reply_ones,
  output logic o_loopback_accept,
  output logic o_loopback_grant,
  output logic o_loopback_reject,
  output logic o_rate_valid,
  output lord_pkg::lord_rate_t o_rate,
  output lord_pkg::lord_parity_t o_parity
);
  import lord_pkg::*;

  // ----------------------------------------
  // option register
  // ----------------------------------------
  lord_byte_t reg_q, reg_d;
  logic rvalid_q, rvalid_d;
  logic [3:0] hund_q, hund_d, tens_q, tens_d, ones_q, ones_d;
  logic grant_q, grant_d, reject_q, reject_d;
  logic rate_ok_q, rate_ok_d;
  lord_dec_if dec ();

  assign dec.value = reg_q;

  lord_bin2dec u_bin2dec (
    .dec(dec.conv)
  );

  always_comb begin
    reg_d = reg_q;
    if (i_wr) begin
      reg_d = i_wr_value & `LORD_USED_MASK;
    end
    // accept/deny commands override only the loopback bit
    if (i_loopback_accept_cmd) begin
      reg_d[`LORD_LB_BIT] = 1'b1;
    end else if (i_loopback_deny_cmd) begin
      reg_d[`LORD_LB_BIT] = 1'b0;
    end
  end

  // ----------------------------------------
  // query reply and loopback answer
  // ----------------------------------------
  always_comb begin
    rvalid_d = i_query;
    hund_d = hund_q;
    tens_d = tens_q;
    ones_d = ones_q;
    if (i_query) begin
      hund_d = dec.hundreds;
      tens_d = dec.tens;
      ones_d = dec.ones;
    end
    grant_d = i_remote_loopback_request & reg_q[`LORD_LB_BIT];
    reject_d = i_remote_loopback_request & ~reg_q[`LORD_LB_BIT];
    // when locked the rate output is frozen; the generator keeps its last setting
    rate_ok_d = ~i_aux_option_register[`LORD_AUX_RATE_LOCK_BIT];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      reg_q <= `LORD_RESET_VALUE;
      rvalid_q <= 1'b0;
      hund_q <= 4'h0;
      tens_q <= 4'h0;
      ones_q <= 4'h0;
      grant_q <= 1'b0;
      reject_q <= 1'b0;
      rate_ok_q <= 1'b0;
    end else begin
      reg_q <= reg_d;
      rvalid_q <= rvalid_d;
      hund_q <= hund_d;
      tens_q <= tens_d;
      ones_q <= ones_d;
      grant_q <= grant_d;
      reject_q <= reject_d;
      rate_ok_q <= rate_ok_d;
    end
  end

  // ----------------------------------------
  // decoded field outputs
  // ----------------------------------------
  lord_rate_t rate_q, rate_d;
  logic lb_q, lb_d;
  lord_parity_t par_q, par_d;
  lord_byte_t val_q, val_d;

  // field outputs trail the storage by one edge so every output leaves a flip-flop
  always_comb begin
    rate_d = rate_q;
    if (rate_ok_q) begin
      rate_d = lord_rate_t'(reg_q[`LORD_RATE_MSB:`LORD_RATE_LSB]);
    end
    lb_d = reg_q[`LORD_LB_BIT];
    par_d = lord_parity_t'(reg_q[`LORD_PAR_MSB:`LORD_PAR_LSB]);
    val_d = reg_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rate_q <= LORD_RATE_19200;
      lb_q <= 1'b1;
      par_q <= LORD_PAR_SPACE;
      val_q <= `LORD_RESET_VALUE;
    end else begin
      rate_q <= rate_d;
      lb_q <= lb_d;
      par_q <= par_d;
      val_q <= val_d;
    end
  end

  assign o_value = val_q;
  assign o_reply_valid = rvalid_q;
  assign o_reply_hundreds = hund_q;
  assign o_reply_tens = tens_q;
  assign o_reply_ones = ones_q;
  assign o_loopback_accept = lb_q;
  assign o_loopback_grant = grant_q;
  assign o_loopback_reject = reject_q;
  assign o_rate_valid = rate_ok_q;
  assign o_rate = rate_q;
  assign o_parity = par_q;
endmodule

/* bench/lord_top_properties.sv */
// assertions for the line option register decode block
`timescale 1ns/1ps
module lord_top_properties (
  input logic i_clk,
  input logic i_reset,
  input logic i_wr,
  input lord_pkg::lord_byte_t i_wr_value,
  input lord_pkg::lord_byte_t i_aux_option_register,
  input logic i_remote_loopback_request,
  input lord_pkg::lord_byte_t o_value,
  input logic o_loopback_accept,
  input logic o_loopback_grant,
  input logic o_rate_valid,
  input lord_pkg::lord_rate_t o_rate,
  input lord_pkg::lord_parity_t o_parity
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_grant; o_loopback_grant == ($past(i_remote_loopback_request) && o_loopback_accept); endproperty
  a_grant: assert property (p_grant) else $error("grant");
  property p_dflt; $fell(i_reset) |-> o_value == 8'h1D && o_rate == 3'h6 && o_parity == 2'h1; endproperty
  a_dflt: assert property (p_dflt) else $error("reset value");
  property p_wr; i_wr |-> ##2 o_value[7:1] == {2'h0, $past(i_wr_value[5:1], 2)}; endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_par; o_parity == o_value[5:4]; endproperty
  a_par: assert property (p_par) else $error("parity");
  property p_lock; !$past(i_reset) |-> o_rate_valid == !$past(i_aux_option_register[3]); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_hold; !o_rate_valid && i_aux_option_register[3] |=> $stable(o_rate); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  c_grant: cover property (o_loopback_grant);
  c_unlock: cover property (!o_rate_valid ##1 o_rate_valid);
  c_wr: cover property (i_wr);
endmodule
bind lord_top lord_top_properties chk (.*);

/* bench/lord_host_model.sv */
// host terminal model: one command pulse per call, then settle time
`timescale 1ns/1ps
module lord_host_model (
  input logic i_clk,
  output lord_pkg::lord_byte_t i_wr_value,
  output logic i_wr,
  output logic i_query,
  output logic i_loopback_accept_cmd,
  output logic i_loopback_deny_cmd
);
  logic [3:0] cmd = 4'h0;
  assign {i_wr, i_query, i_loopback_accept_cmd, i_loopback_deny_cmd} = cmd;
  initial i_wr_value = 8'h00;
  task automatic send(input logic [3:0] k, input logic [7:0] v);
    @(negedge i_clk);
    cmd = k;
    i_wr_value = v;
    @(negedge i_clk);
    cmd = 4'h0;
    i_wr_value = ~v;
    repeat (3) @(negedge i_clk);
  endtask
endmodule

/* bench/tb_lord_top.sv */
// self-checking bench for the line option register decode block
`timescale 1ns/1ps
module tb_lord_top;
  import lord_pkg::*;
  logic i_clk = 0, i_reset = 1, i_remote_loopback_request = 0, i_wr, i_query, i_loopback_accept_cmd;
  logic i_loopback_deny_cmd, o_reply_valid, o_loopback_accept, o_loopback_grant, o_loopback_reject;
  logic o_rate_valid;
  logic [3:0] o_reply_hundreds, o_reply_tens, o_reply_ones;
  lord_byte_t i_wr_value, o_value, i_aux_option_register = 8'h00;
  lord_rate_t o_rate;
  lord_parity_t o_parity;
  int fails = 0, num_checks = 0, cyc = 0, replies = 0;
  // reply valid stands one cycle, so one falling edge sees each pulse
  always @(negedge i_clk) if (o_reply_valid === 1'b1) replies++;
  always #5 i_clk = ~i_clk;
  lord_top uut (.*);
  lord_host_model host (.*);
  task automatic chk(input logic [19:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t saw %h", $time, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 300) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(negedge i_clk);
    i_reset = 0;
    host.send(4'h4, 8'h00);
    chk({o_reply_hundreds, o_reply_tens, o_reply_ones, o_parity, o_rate}, {12'h029, 2'h1, 3'h6});
    $display("defaults done");
    // bits 7..6 written high on purpose, so every rate code also shows they are dropped
    for (int r = 0; r < 8; r++) begin
      host.send(4'h8, {4'hE, r[2:0], 1'b1});
      chk({o_value, o_rate}, {4'h2, r[2:0], 1'b1, r[2:0]});
    end
    host.send(4'h4, 8'h00);
    chk({o_reply_hundreds, o_reply_tens, o_reply_ones}, 12'h047);
    $display("writes done");
    i_aux_option_register = 8'h08;
    host.send(4'h8, 8'h02);
    chk({o_rate_valid, o_rate, o_value}, {4'h7, 8'h02});
    i_aux_option_register = 8'h00;
    i_remote_loopback_request = 1;
    repeat (3) @(negedge i_clk);
    chk({o_rate, o_loopback_grant, o_loopback_reject}, 5'h05);
    host.send(4'h2, 8'h00);
    chk({o_loopback_accept, o_loopback_grant, o_loopback_reject}, 3'h6);
    host.send(4'h1, 8'h00);
    chk({o_loopback_accept, o_loopback_grant, o_loopback_reject}, 3'h1);
    $display("lock and loopback done");
    chk(replies, 2);
    tally_and_finish;
  end
endmodule
